/* File: hdl/adc_seq_pkg.sv */
// Constants and carrier types for the converter sequencing block
//
// What this block does
// - The result is an unsigned 10-bit code from 000h to 3FFh, clamped at either reference.
// - The sample-and-hold window lasts between 2 and 32 converter clock periods.
// - The window length is chosen by the acquisition prescaler field of the control register.
// - The conversion phase lasts at least 10 converter clock periods.
// - Sampling starts two CPU clock periods after a start request.
// - The result register loads two CPU clock periods after conversion ends if tot_q stays below FFh; once tot_q saturates at FFh the load stalls.
// - The interrupt request rises two CPU clock periods after the completion flag sets.
// - Total conversion time is start delay plus window plus conversion plus load delay.
// - One full conversion takes no less than 500 ns.
// - The converter clock period never falls below 33.3 ns.
package adc_seq_pkg;
    localparam int unsigned RES_W         = 10;
    localparam logic [9:0]  RESULT_MIN    = 10'h000;
    localparam logic [9:0]  RESULT_MAX    = 10'h3FF;
    localparam int unsigned CLK_PERIOD_PS = 100000;
    localparam int unsigned ADC_MIN_PS    = 33300;
    localparam int unsigned TOTAL_MIN_NS  = 500;
    localparam int unsigned TOTAL_MIN_CYC = (TOTAL_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
    localparam int unsigned SH_MIN_TAD    = 2;
    localparam int unsigned SH_MAX_TAD    = 32;
    localparam int unsigned CONV_TAD      = 10;
    localparam int unsigned SOC_DLY_CYC   = 2;
    localparam int unsigned EOC_DLY_CYC   = 2;
    localparam int unsigned INT_DLY_CYC   = 2;
    localparam int unsigned ACQ_W         = 4;
    localparam int unsigned CLKDIV_W      = 4;
    localparam logic [3:0]  ACQ_RESET     = 4'h0;
    localparam logic [3:0]  CLKDIV_RESET  = 4'h0;

    // Control register one: prescaler of converter clock and acquisition window
    typedef struct packed {
        logic [3:0] acquisition_window_prescaler;
        logic [3:0] adc_clk_div;
    } converter_control_one_t;

    // Front end pins: sample-and-hold and convert strobes
    typedef struct packed {
        logic sample;
        logic convert;
    } front_end_t;
endpackage

/* File: hdl/adc_tick_gen.sv */
// Prescaled converter clock tick generator
`timescale 1ns/1ps
module adc_tick_gen #(
    parameter int unsigned DIV_W = 4
) (
    input  wire logic             sys_clk_in,
    input  wire logic             srst_in,
    input  wire logic             run_in,
    input  wire logic [DIV_W-1:0] div_in,
    output logic                  tick_out
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             tick_d;

    if (DIV_W < 1 || DIV_W > 8) begin : g_div_w_check
        $error("Divider width out of range");
    end

    // Divider value N gives one tick every N+1 system clocks.
    // Tick is decoded from the count: a registered tick would stretch each phase by a clock.
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run_in) begin
            cnt_d = '0;
        end else if (cnt_q >= div_in) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick_out = tick_d;
endmodule

/* File: hdl/adc_conversion_sequencing.sv */
// Sequencer for one 10-bit conversion: start delay, sample, convert, load, interrupt
`timescale 1ns/1ps
module adc_conversion_sequencing (
    input  wire logic                                      sys_clk_in,
    input  wire logic                                      srst_in,
    input  wire logic                                      soc_in,
    input  wire adc_seq_pkg::converter_control_one_t       ctrl_in,
    input  wire logic [9:0]                                raw_code_in,
    input  wire logic                                      below_low_ref_in,
    input  wire logic                                      above_high_ref_in,
    input  wire logic                                      flag_clr_in,
    output adc_seq_pkg::front_end_t                        front_end_out,
    output logic [9:0]                                     result_out,
    output logic                                           done_flag_out,
    output logic                                           irq_out,
    output logic                                           busy_out
);
    // 10 MHz clock: every divider setting gives >= 100 ns, above the 33.3 ns floor
    initial begin
        if (adc_seq_pkg::CLK_PERIOD_PS < adc_seq_pkg::ADC_MIN_PS) begin
            $error("System clock too fast for converter clock floor");
        end
    end

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_START = 5'b00010,
        S_SAMP  = 5'b00100,
        S_CONV  = 5'b01000,
        S_LOAD  = 5'b10000
    } state_t;

    state_t     st_q;
    state_t     st_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [5:0] sh_len;
    logic [7:0] tot_q;
    logic [7:0] tot_d;
    logic [3:0] div_q;
    logic [3:0] div_d;
    logic [3:0] acq_q;
    logic [3:0] acq_d;
    logic [9:0] res_q;
    logic [9:0] res_d;
    logic       flag_q;
    logic       flag_d;
    logic [2:0] irq_pipe_q;
    logic [2:0] irq_pipe_d;
    logic       soc_s1_q;
    logic       soc_s2_q;
    logic       soc_s3_q;
    logic       soc_rise;
    logic       tick;
    logic [9:0] clamped;

    adc_tick_gen #(
        .DIV_W (adc_seq_pkg::CLKDIV_W)
    ) u_tick (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .run_in     (st_q == S_SAMP || st_q == S_CONV),
        .div_in     (div_q),
        .tick_out   (tick)
    );

    // Window = 2 + 2*prescaler converter periods, spanning 2..32
    assign sh_len   = 6'(adc_seq_pkg::SH_MIN_TAD) + {1'b0, acq_q, 1'b0};
    assign soc_rise = soc_s2_q && !soc_s3_q;

    always_comb begin
        clamped = raw_code_in;
        if (below_low_ref_in) begin
            clamped = adc_seq_pkg::RESULT_MIN;
        end else if (above_high_ref_in) begin
            clamped = adc_seq_pkg::RESULT_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        // Saturates at FFh, where the 8-bit tot_q + 8'h01 compare wraps to 0 and stalls the load
        tot_d = (st_q == S_IDLE) ? 8'h00 : ((tot_q == 8'hFF) ? tot_q : tot_q + 8'h01);
        div_d = div_q;
        acq_d = acq_q;
        res_d = res_q;
        unique case (st_q)
            S_IDLE: begin
                // Settings are latched per conversion so a mid-run write cannot tear it
                if (soc_rise) begin
                    st_d  = S_START;
                    cnt_d = 6'h01;
                    div_d = ctrl_in.adc_clk_div;
                    acq_d = ctrl_in.acquisition_window_prescaler;
                end
            end
            S_START: begin
                if (cnt_q >= 6'(adc_seq_pkg::SOC_DLY_CYC)) begin
                    st_d  = S_SAMP;
                    cnt_d = 6'h00;
                end else begin
                    cnt_d = cnt_q + 6'h01;
                end
            end
            S_SAMP: begin
                if (tick) begin
                    if (cnt_q + 6'h01 >= sh_len) begin
                        st_d  = S_CONV;
                        cnt_d = 6'h00;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
            end
            S_CONV: begin
                if (tick) begin
                    if (cnt_q + 6'h01 >= 6'(adc_seq_pkg::CONV_TAD)) begin
                        st_d  = S_LOAD;
                        cnt_d = 6'h01;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
            end
            S_LOAD: begin
                // Load delay elapses, then total is checked against 500 ns floor
                if (cnt_q >= 6'(adc_seq_pkg::EOC_DLY_CYC)
                    && tot_q + 8'h01 >= 8'(adc_seq_pkg::TOTAL_MIN_CYC)) begin
                    st_d  = S_IDLE;
                    res_d = clamped;
                end else if (cnt_q < 6'(adc_seq_pkg::EOC_DLY_CYC)) begin
                    cnt_d = cnt_q + 6'h01;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st_q  <= S_IDLE;
            cnt_q <= 6'h00;
            tot_q <= 8'h00;
            div_q <= adc_seq_pkg::CLKDIV_RESET;
            acq_q <= adc_seq_pkg::ACQ_RESET;
            res_q <= adc_seq_pkg::RESULT_MIN;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            tot_q <= tot_d;
            div_q <= div_d;
            acq_q <= acq_d;
            res_q <= res_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start request comes from outside, so it is synchronised before edge detect
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            soc_s1_q <= 1'b0;
            soc_s2_q <= 1'b0;
            soc_s3_q <= 1'b0;
        end else begin
            soc_s1_q <= soc_in;
            soc_s2_q <= soc_s1_q;
            soc_s3_q <= soc_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic load_now;
    assign load_now = (st_q == S_LOAD) && (st_d == S_IDLE);

    always_comb begin
        flag_d = flag_q;
        if (flag_clr_in) begin
            flag_d = 1'b0;
        end
        if (load_now) begin
            flag_d = 1'b1;
        end
        // Flag rises with the first stage, so the request lands two clocks after it
        irq_pipe_d = {irq_pipe_q[1:0], load_now};
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            flag_q     <= 1'b0;
            irq_pipe_q <= 3'h0;
        end else begin
            flag_q     <= flag_d;
            irq_pipe_q <= irq_pipe_d;
        end
    end

    assign front_end_out.sample  = (st_q == S_SAMP);
    assign front_end_out.convert = (st_q == S_CONV);
    assign result_out            = res_q;
    assign done_flag_out         = flag_q;
    assign irq_out               = irq_pipe_q[2];
    assign busy_out              = (st_q != S_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    logic [6:0] sh_cnt_q;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in || st_q != S_SAMP) begin
            sh_cnt_q <= 7'h00;
        end else if (tick) begin
            sh_cnt_q <= sh_cnt_q + 7'h01;
        end
    end

    a_start_delay: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (st_q == S_IDLE && soc_rise) |=> (st_q == S_START) ##2 (st_q == S_SAMP))
        else $error("sampling did not start two cycles after request");
    a_window_max: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (st_q == S_SAMP) |-> (sh_cnt_q <= 7'h20))
        else $error("sample window exceeded 32 periods");
    a_window_min: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (st_q == S_SAMP && st_d == S_CONV) |-> (sh_cnt_q + 7'h01 == {1'b0, sh_len}))
        else $error("sample window length differs from prescaler");
    a_flag_load: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        $rose(flag_q) |-> $past(load_now))
        else $error("flag set without result load");
    a_irq_delay: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        $rose(flag_q) |-> ##2 irq_out)
        else $error("interrupt not two cycles after flag");
    a_ignore_busy: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        ((st_q == S_SAMP || st_q == S_CONV || st_q == S_LOAD) && soc_rise)
        |=> (st_q != S_START && $stable(acq_q) && $stable(div_q)))
        else $error("start request taken during conversion");
    a_total_min: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        load_now |-> (tot_q + 8'h01 >= 8'(adc_seq_pkg::TOTAL_MIN_CYC)))
        else $error("conversion shorter than 500 ns");
    a_result_range: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (load_now && above_high_ref_in && !below_low_ref_in) |=> (result_out == 10'h3FF))
        else $error("high input not clamped");
endmodule

/* File: sim/adc_front_end_model.sv */
// Behavioural analog front end: tracks the input while sampling, holds it afterwards
`timescale 1ns/1ps
module adc_front_end_model (
    input  wire logic                    sys_clk_in,
    input  wire adc_seq_pkg::front_end_t front_end_in,
    input  wire logic signed [11:0]      level_in,
    output logic [9:0]                   raw_code_out,
    output logic                         below_low_ref_out,
    output logic                         above_high_ref_out
);
    logic signed [11:0] held_q = 12'sh000;

    always @(posedge sys_clk_in) begin
        if (front_end_in.sample) begin
            held_q <= level_in;
        end
    end
    // Out-of-range codes are junk on purpose, so only the clamp flags give the right answer
    assign below_low_ref_out  = held_q <= 12'sh000;
    assign above_high_ref_out = held_q >= 12'sh3FF;
    assign raw_code_out       = (below_low_ref_out || above_high_ref_out) ? 10'h2AA
                                                                          : held_q[9:0];
endmodule

/* File: sim/adc_conversion_sequencing_tb.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencing_tb;
    logic                               sys_clk_in;
    logic                               srst_in;
    logic                               soc_in;
    adc_seq_pkg::converter_control_one_t ctrl_in;
    logic [9:0]                         raw_code;
    logic                               below_low;
    logic                               above_high;
    logic                               flag_clr_in;
    adc_seq_pkg::front_end_t            front_end;
    logic [9:0]                         result;
    logic                               done_flag;
    logic                               irq;
    logic                               busy;
    logic signed [11:0]                 level;
    int                                 n_fail;
    int                                 compares;
    int                                 cyc;

    adc_conversion_sequencing dut (
        .sys_clk_in       (sys_clk_in),
        .srst_in          (srst_in),
        .soc_in           (soc_in),
        .ctrl_in          (ctrl_in),
        .raw_code_in      (raw_code),
        .below_low_ref_in (below_low),
        .above_high_ref_in(above_high),
        .flag_clr_in      (flag_clr_in),
        .front_end_out    (front_end),
        .result_out       (result),
        .done_flag_out    (done_flag),
        .irq_out          (irq),
        .busy_out         (busy)
    );

    adc_front_end_model front (
        .sys_clk_in        (sys_clk_in),
        .front_end_in      (front_end),
        .level_in          (level),
        .raw_code_out      (raw_code),
        .below_low_ref_out (below_low),
        .above_high_ref_out(above_high)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_int(input string what, input int exp, input int got);
        compares++;
        if (exp != got) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic chk_code(input string what, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (exp !== got) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One conversion, optionally with a second start edge while converting
    task automatic run_conv(input logic [3:0] acq, input logic [3:0] div,
                            input logic [11:0] vin, input logic [9:0] exp, input bit again);
        int         s_len;
        int         c_len;
        int         t_sr;
        int         t_cf;
        int         t_fl;
        int         t_irq;
        int         irqs;
        logic       c_p;
        logic [9:0] res_fl;
        s_len = 0; c_len = 0; t_sr = -1; t_cf = -1; t_fl = -1; t_irq = -1; irqs = 0;
        c_p = 1'b0;
        // Flag is sticky: clear it first or its rise for this run never shows
        @(posedge sys_clk_in);
        ctrl_in     <= '{acq, div};
        level       <= vin;
        soc_in      <= 1'b1;
        flag_clr_in <= 1'b1;
        for (int n = 0; n < 1200; n++) begin
            @(posedge sys_clk_in);
            if (n == 0) flag_clr_in <= 1'b0;
            if (n == 4) soc_in <= 1'b0;
            if (again && c_len == 3) soc_in <= 1'b1;
            #1;
            if (front_end.sample === 1'b1 && t_sr < 0) t_sr = n;
            if (front_end.sample === 1'b1) s_len++;
            if (front_end.convert === 1'b1) c_len++;
            if (c_p && front_end.convert !== 1'b1) t_cf = n;
            c_p = (front_end.convert === 1'b1);
            if (done_flag === 1'b1 && t_fl < 0) begin
                t_fl = n;
                res_fl = result;
            end
            if (irq === 1'b1) begin
                irqs++;
                t_irq = n;
            end
            if (t_irq >= 0 && n == t_irq + 15) break;
        end
        @(posedge sys_clk_in);
        soc_in <= 1'b0;
        chk_int("start_delay_ok", int'(t_sr >= 3 && t_sr <= 6), 1);
        chk_int("sample_len", (2 + 2 * acq) * (div + 1), s_len);
        chk_int("convert_len", 10 * (div + 1), c_len);
        chk_int("load_delay", int'(adc_seq_pkg::EOC_DLY_CYC), t_fl - t_cf);
        chk_int("total_ok", int'(t_fl >= int'(adc_seq_pkg::TOTAL_MIN_CYC)), 1);
        chk_code("result_at_flag", exp, res_fl);
        chk_int("irq_delay", 2, t_irq - t_fl);
        chk_int("irq_count", 1, irqs);
        chk_int("busy_after", 0, int'(busy !== 1'b0));
    endtask

    task automatic clear_flag();
        @(posedge sys_clk_in);
        flag_clr_in <= 1'b1;
        @(posedge sys_clk_in);
        flag_clr_in <= 1'b0;
        #1;
        chk_int("flag_cleared", 0, int'(done_flag !== 1'b0));
    endtask

    // Reset in the middle of a conversion must drop everything back to idle
    task automatic reset_mid_run();
        @(posedge sys_clk_in);
        soc_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        srst_in <= 1'b1;
        soc_in  <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk_int("reset_busy", 0, int'(busy !== 1'b0 || front_end !== 2'h0
                                      || done_flag !== 1'b0 || irq !== 1'b0));
        chk_code("reset_result", 10'h000, result);
        @(posedge sys_clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst_in = 1'b1; soc_in = 1'b0; flag_clr_in = 1'b0;
        ctrl_in = '0; level = 12'sh000; n_fail = 0; compares = 0;
        repeat (20) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        run_conv(4'h0, 4'h0, 12'h12C, 10'h12C, 1'b0);
        clear_flag();
        // Each result differs from the one before, so a missed load shows
        run_conv(4'h1, 4'h0, 12'h3FF, 10'h3FF, 1'b1);
        run_conv(4'hF, 4'h1, 12'hFFB, 10'h000, 1'b1);
        run_conv(4'h3, 4'h2, 12'h7D0, 10'h3FF, 1'b0);
        reset_mid_run();
        run_conv(4'h2, 4'h0, 12'h001, 10'h001, 1'b0);
        run_conv(4'h0, 4'h0, 12'h000, 10'h000, 1'b0);
        complete_run();
    end

    initial begin
        cyc = 0;
        forever begin
            @(posedge sys_clk_in);
            cyc++;
            if (cyc == 20000) begin
                n_fail++;
                complete_run();
            end
        end
    end
endmodule
